// ==== design/pcs_pkg.sv ====
// Package: register map, field layout, reset values and encodings of the multipurpose port
`default_nettype none
package pcs_pkg;
  localparam int NPINS = 4;
  // Byte addresses on the special function register port
  localparam logic [7:0] ADDR_EXTRA_IRQ_CONTROL = 8'hc0;
  localparam logic [7:0] ADDR_LOW_PINS_CONFIG = 8'hc2;
  localparam logic [7:0] ADDR_HIGH_PINS_CONFIG = 8'hc3;
  localparam logic [7:0] ADDR_PIN_DATA = 8'hd8;
  localparam logic [7:0] ADDR_STROBE_POLARITY = 8'hae;
  localparam logic [7:0] ADDR_BASE_LOW [NPINS] = '{8'h84, 8'h94, 8'hac, 8'hb4};
  localparam logic [7:0] ADDR_BASE_HIGH [NPINS] = '{8'h85, 8'h95, 8'had, 8'hb5};
  // Bit-addressable registers span eight bit addresses from their byte address
  localparam logic [4:0] BITSPACE_IRQ = 5'h18;
  localparam logic [4:0] BITSPACE_DATA = 5'h1b;
  // Reset values
  localparam logic [7:0] RST_PIN_DATA = 8'h0f;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Polarity register: pins 3..0 at bits 7..4, bits 3:0 read zero
  localparam int POL_LSB = 4;
  // Config byte: even pin in bits 3:0, odd pin in bits 7:4; function above width
  localparam int CFG_FUN_POS = 2;
  localparam int CFG_CMP_POS = 0;
  localparam int CFG_PIN_SPAN = 4;
  // Extra interrupt control bit positions
  localparam int XI_TYPE2 = 0;
  localparam int XI_FLAG2 = 1;
  localparam int XI_EN2 = 2;
  localparam int XI_PRIO2 = 3;
  localparam int XI_TYPE3 = 4;
  localparam int XI_FLAG3 = 5;
  localparam int XI_EN3 = 6;
  localparam int XI_PRIO3 = 7;
  // Interrupt vectors and polling ranks
  localparam logic [7:0] VEC_IRQ_TWO = 8'h33;
  localparam logic [7:0] VEC_IRQ_THREE = 8'h3b;
  localparam logic [7:0] VEC_NONE = 8'h00;
  localparam int POLL_IRQ_TWO = 6;
  localparam int POLL_IRQ_THREE = 7;
  // Pins that feed the extra interrupts
  localparam int PIN_IRQ_TWO = 3;
  localparam int PIN_IRQ_THREE = 2;

  typedef enum logic [1:0] {
    MODE_GPIO = 2'b00,
    MODE_RD = 2'b01,
    MODE_WR = 2'b10,
    MODE_RW = 2'b11
  } pcs_mode_e;

  typedef enum logic [1:0] {
    CMP_FULL = 2'b00,
    CMP_A15_A1 = 2'b01,
    CMP_A15_A2 = 2'b10,
    CMP_A15_A8 = 2'b11
  } pcs_cmp_e;

  localparam logic [15:0] MASK_FULL = 16'hffff;
  localparam logic [15:0] MASK_A15_A1 = 16'hfffe;
  localparam logic [15:0] MASK_A15_A2 = 16'hfffc;
  localparam logic [15:0] MASK_A15_A8 = 16'hff00;
endpackage
`default_nettype wire

// ==== design/pcs_irq_if.sv ====
// Interface between the port core and the extra interrupt edge detector
`default_nettype none
interface pcs_irq_if;
  logic [1:0] level;
  logic [1:0] falling;
  modport core (output level, input falling);
  modport det (input level, output falling);
endinterface
`default_nettype wire

// ==== design/pcs_edge_det.sv ====
// Falling-edge detector for the two extra interrupt inputs
`default_nettype none
module pcs_edge_det (
  input wire logic clock,   // Core clock
  input wire logic arst_n,  // Async reset, active low
  pcs_irq_if.det irq        // Levels in, falling-edge pulses out
);
  logic [1:0] prev_r;
  logic [1:0] prev_nxt;

  always_comb begin
    prev_nxt = irq.level;
    irq.falling = prev_r & ~irq.level;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_r <= 2'b11;
    end else begin
      prev_r <= prev_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== design/pcs_decode.sv ====
// Address comparators and strobe qualification for the four port pins
`default_nettype none
module pcs_decode #(
  parameter int NPINS = 4
) (
  input wire logic [NPINS*16-1:0] base,  // Base addresses, pin 0 lowest
  input wire logic [NPINS*2-1:0] fun,    // Function fields
  input wire logic [NPINS*2-1:0] cmp,    // Compare-width fields
  input wire logic [15:0] addr,          // External access address
  input wire logic rd_n,                 // External read strobe, active low
  input wire logic wr_n,                 // External write strobe, active low
  output logic [NPINS-1:0] match,        // Address in pin range
  output logic [NPINS-1:0] active        // Strobe should be asserted
);
  function automatic logic [15:0] cmp_mask(input logic [1:0] w);
    case (w)
      pcs_pkg::CMP_FULL: cmp_mask = pcs_pkg::MASK_FULL;
      pcs_pkg::CMP_A15_A1: cmp_mask = pcs_pkg::MASK_A15_A1;
      pcs_pkg::CMP_A15_A2: cmp_mask = pcs_pkg::MASK_A15_A2;
      default: cmp_mask = pcs_pkg::MASK_A15_A8;
    endcase
  endfunction

  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      match[i] = ((addr ^ base[i*16 +: 16]) & cmp_mask(cmp[i*2 +: 2])) == 16'h0000;
      case (fun[i*2 +: 2])
        pcs_pkg::MODE_RD: active[i] = match[i] & ~rd_n;
        pcs_pkg::MODE_WR: active[i] = match[i] & ~wr_n;
        pcs_pkg::MODE_RW: active[i] = match[i] & (~rd_n | ~wr_n);
        default: active[i] = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== design/pcs_port4.sv ====
// Multipurpose four-pin port: quasi I/O, chip-select strobes and two extra interrupts
// What this block does
// - Four pins, each configured independently.
// - Mode 0 quasi-port; pins 2,3 feed interrupts.
// - Mode 1 read strobe on address match.
// - Mode 2 write strobe on address match.
// - Mode 3 strobe on read or write match.
// - Each pin has high/low base address bytes.
// - Width 00 compares all sixteen address bits.
// - Width 01 ignores address bit 0.
// - Width 10 ignores address bits 1:0.
// - Width 11 compares only the high byte.
// - High config holds pin 3 and pin 2.
// - Low config holds pin 1 and pin 0.
// - Interrupt control is bit addressable, C2 enable.
// - Control bits: prio,en,flag,type for 3 then 2.
// - Priority bit raises level; enable allows interrupt.
// - Type one falling edge, zero low level.
// - Edge flag set by hardware, cleared on service.
// - Vectors 33H and 3BH, two polled first.
// - Data bits 3:0 drive pins in mode 0.
// - Polarity bits 7:4 select strobe active level.
`default_nettype none
module pcs_port4 #(
  parameter int NPINS = 4
) (
  input wire logic clock,              // Core clock, 100 MHz
  input wire logic arst_n,             // Async reset, active low
  input wire logic [7:0] sfr_addr,     // Register byte address
  input wire logic sfr_wr,             // Byte write strobe
  input wire logic [7:0] sfr_wdata,    // Byte write data
  output logic [7:0] sfr_rdata,        // Read data, one cycle after address
  input wire logic [7:0] bit_addr,     // Bit address for set/clear instructions
  input wire logic bit_wr,             // Single-bit write strobe
  input wire logic bit_wval,           // Value written to the addressed bit
  input wire logic [15:0] ext_addr,    // External data access address
  input wire logic ext_rd_n,           // External read strobe, active low
  input wire logic ext_wr_n,           // External write strobe, active low
  input wire logic [NPINS-1:0] pin_in, // Pin levels
  output logic [NPINS-1:0] pin_out,    // Pin drive values
  output logic [NPINS-1:0] pin_oe,     // Pin drive enables, high drives
  input wire logic irq_two_ack,        // Interrupt two serviced, pulse
  input wire logic irq_three_ack,      // Interrupt three serviced, pulse
  output logic irq_two_req,            // Interrupt two request
  output logic irq_three_req,          // Interrupt three request
  output logic irq_two_high,           // Interrupt two at high priority
  output logic irq_three_high,         // Interrupt three at high priority
  output logic [7:0] irq_vector        // Vector of first pending extra interrupt
);
  logic [7:0] extra_irq_control_r, extra_irq_control_nxt;
  logic [7:0] cfg_lo_r, cfg_lo_nxt;
  logic [7:0] cfg_hi_r, cfg_hi_nxt;
  logic [7:0] data_r, data_nxt;
  logic [3:0] pol_r, pol_nxt;
  logic [7:0] base_lo_r [NPINS];
  logic [7:0] base_lo_nxt [NPINS];
  logic [7:0] base_hi_r [NPINS];
  logic [7:0] base_hi_nxt [NPINS];
  logic [7:0] rdata_r, rdata_nxt;
  logic [NPINS-1:0] out_r, out_nxt, oe_r, oe_nxt;
  logic req2_r, req2_nxt, req3_r, req3_nxt;
  logic hi2_r, hi2_nxt, hi3_r, hi3_nxt;
  logic [7:0] vec_r, vec_nxt;
  logic [NPINS*16-1:0] base_flat;
  logic [NPINS*2-1:0] fun_flat, cmp_flat;
  logic [NPINS-1:0] match, active, gpio;
  logic in2, in3;

  pcs_irq_if irq_if ();

  // Per-pin field extraction from the two config bytes
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (i >= 2) begin
        fun_flat[i*2 +: 2] =
          cfg_hi_r[(i % 2)*pcs_pkg::CFG_PIN_SPAN + pcs_pkg::CFG_FUN_POS +: 2];
        cmp_flat[i*2 +: 2] =
          cfg_hi_r[(i % 2)*pcs_pkg::CFG_PIN_SPAN + pcs_pkg::CFG_CMP_POS +: 2];
      end else begin
        fun_flat[i*2 +: 2] = cfg_lo_r[i*pcs_pkg::CFG_PIN_SPAN + pcs_pkg::CFG_FUN_POS +: 2];
        cmp_flat[i*2 +: 2] = cfg_lo_r[i*pcs_pkg::CFG_PIN_SPAN + pcs_pkg::CFG_CMP_POS +: 2];
      end
      base_flat[i*16 +: 16] = {base_hi_r[i], base_lo_r[i]};
      gpio[i] = fun_flat[i*2 +: 2] == pcs_pkg::MODE_GPIO;
    end
    // A pin in strobe mode reads as idle-high so it never raises an interrupt
    in2 = gpio[pcs_pkg::PIN_IRQ_TWO] ? pin_in[pcs_pkg::PIN_IRQ_TWO] : 1'b1;
    in3 = gpio[pcs_pkg::PIN_IRQ_THREE] ? pin_in[pcs_pkg::PIN_IRQ_THREE] : 1'b1;
    irq_if.level = {in3, in2};
  end

  pcs_edge_det u_edge (
    .clock(clock),
    .arst_n(arst_n),
    .irq(irq_if.det)
  );

  pcs_decode #(.NPINS(NPINS)) u_decode (
    .base(base_flat),
    .fun(fun_flat),
    .cmp(cmp_flat),
    .addr(ext_addr),
    .rd_n(ext_rd_n),
    .wr_n(ext_wr_n),
    .match(match),
    .active(active)
  );

  // Register file: byte writes, bit writes, hardware flag updates
  always_comb begin
    logic fall2;
    logic fall3;
    fall2 = irq_if.falling[0];
    fall3 = irq_if.falling[1];
    extra_irq_control_nxt = extra_irq_control_r;
    cfg_lo_nxt = cfg_lo_r;
    cfg_hi_nxt = cfg_hi_r;
    data_nxt = data_r;
    pol_nxt = pol_r;
    base_lo_nxt = base_lo_r;
    base_hi_nxt = base_hi_r;
    if (irq_two_ack && extra_irq_control_r[pcs_pkg::XI_TYPE2]) begin
      extra_irq_control_nxt[pcs_pkg::XI_FLAG2] = 1'b0;
    end
    if (irq_three_ack && extra_irq_control_r[pcs_pkg::XI_TYPE3]) begin
      extra_irq_control_nxt[pcs_pkg::XI_FLAG3] = 1'b0;
    end
    if (sfr_wr) begin
      case (sfr_addr)
        pcs_pkg::ADDR_EXTRA_IRQ_CONTROL: extra_irq_control_nxt = sfr_wdata;
        pcs_pkg::ADDR_LOW_PINS_CONFIG: cfg_lo_nxt = sfr_wdata;
        pcs_pkg::ADDR_HIGH_PINS_CONFIG: cfg_hi_nxt = sfr_wdata;
        pcs_pkg::ADDR_PIN_DATA: data_nxt = sfr_wdata;
        pcs_pkg::ADDR_STROBE_POLARITY: pol_nxt = sfr_wdata[pcs_pkg::POL_LSB +: 4];
        default: begin
          for (int i = 0; i < NPINS; i++) begin
            if (sfr_addr == pcs_pkg::ADDR_BASE_LOW[i]) begin
              base_lo_nxt[i] = sfr_wdata;
            end
            if (sfr_addr == pcs_pkg::ADDR_BASE_HIGH[i]) begin
              base_hi_nxt[i] = sfr_wdata;
            end
          end
        end
      endcase
    end
    if (bit_wr && bit_addr[7:3] == pcs_pkg::BITSPACE_IRQ) begin
      extra_irq_control_nxt[bit_addr[2:0]] = bit_wval;
    end
    if (bit_wr && bit_addr[7:3] == pcs_pkg::BITSPACE_DATA) begin
      data_nxt[bit_addr[2:0]] = bit_wval;
    end
    // Hardware set wins over any clear in the same cycle
    if (fall2 && extra_irq_control_r[pcs_pkg::XI_TYPE2]) begin
      extra_irq_control_nxt[pcs_pkg::XI_FLAG2] = 1'b1;
    end
    if (fall3 && extra_irq_control_r[pcs_pkg::XI_TYPE3]) begin
      extra_irq_control_nxt[pcs_pkg::XI_FLAG3] = 1'b1;
    end
  end

  // Read data, pin drive and interrupt outputs
  always_comb begin
    rdata_nxt = 8'h00;
    case (sfr_addr)
      pcs_pkg::ADDR_EXTRA_IRQ_CONTROL: rdata_nxt = extra_irq_control_r;
      pcs_pkg::ADDR_LOW_PINS_CONFIG: rdata_nxt = cfg_lo_r;
      pcs_pkg::ADDR_HIGH_PINS_CONFIG: rdata_nxt = cfg_hi_r;
      pcs_pkg::ADDR_PIN_DATA: rdata_nxt = {4'h0, pin_in};
      pcs_pkg::ADDR_STROBE_POLARITY: rdata_nxt = {pol_r, 4'h0};
      default: begin
        for (int i = 0; i < NPINS; i++) begin
          if (sfr_addr == pcs_pkg::ADDR_BASE_LOW[i]) begin
            rdata_nxt = base_lo_r[i];
          end
          if (sfr_addr == pcs_pkg::ADDR_BASE_HIGH[i]) begin
            rdata_nxt = base_hi_r[i];
          end
        end
      end
    endcase
    for (int i = 0; i < NPINS; i++) begin
      if (gpio[i]) begin
        // Quasi-bidirectional: drive only a low, a one is left to the pull-up
        out_nxt[i] = data_r[i];
        oe_nxt[i] = ~data_r[i];
      end else begin
        out_nxt[i] = pol_r[i] ? active[i] : ~active[i];
        oe_nxt[i] = 1'b1;
      end
    end
    req2_nxt = extra_irq_control_r[pcs_pkg::XI_EN2] &
               (extra_irq_control_r[pcs_pkg::XI_TYPE2] ? extra_irq_control_r[pcs_pkg::XI_FLAG2] : ~in2);
    req3_nxt = extra_irq_control_r[pcs_pkg::XI_EN3] &
               (extra_irq_control_r[pcs_pkg::XI_TYPE3] ? extra_irq_control_r[pcs_pkg::XI_FLAG3] : ~in3);
    hi2_nxt = extra_irq_control_r[pcs_pkg::XI_PRIO2];
    hi3_nxt = extra_irq_control_r[pcs_pkg::XI_PRIO3];
    if (req2_nxt) begin
      vec_nxt = pcs_pkg::VEC_IRQ_TWO;
    end else if (req3_nxt) begin
      vec_nxt = pcs_pkg::VEC_IRQ_THREE;
    end else begin
      vec_nxt = pcs_pkg::VEC_NONE;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      extra_irq_control_r <= pcs_pkg::RST_ZERO;
      cfg_lo_r <= pcs_pkg::RST_ZERO;
      cfg_hi_r <= pcs_pkg::RST_ZERO;
      data_r <= pcs_pkg::RST_PIN_DATA;
      pol_r <= 4'h0;
      for (int i = 0; i < NPINS; i++) begin
        base_lo_r[i] <= pcs_pkg::RST_ZERO;
        base_hi_r[i] <= pcs_pkg::RST_ZERO;
      end
      rdata_r <= pcs_pkg::RST_ZERO;
      out_r <= '1;
      oe_r <= '0;
      req2_r <= 1'b0;
      req3_r <= 1'b0;
      hi2_r <= 1'b0;
      hi3_r <= 1'b0;
      vec_r <= pcs_pkg::VEC_NONE;
    end else begin
      extra_irq_control_r <= extra_irq_control_nxt;
      cfg_lo_r <= cfg_lo_nxt;
      cfg_hi_r <= cfg_hi_nxt;
      data_r <= data_nxt;
      pol_r <= pol_nxt;
      base_lo_r <= base_lo_nxt;
      base_hi_r <= base_hi_nxt;
      rdata_r <= rdata_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      req2_r <= req2_nxt;
      req3_r <= req3_nxt;
      hi2_r <= hi2_nxt;
      hi3_r <= hi3_nxt;
      vec_r <= vec_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  assign pin_out = out_r;
  assign pin_oe = oe_r;
  assign irq_two_req = req2_r;
  assign irq_three_req = req3_r;
  assign irq_two_high = hi2_r;
  assign irq_three_high = hi3_r;
  assign irq_vector = vec_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_strobe_idle: assert property (
    (!gpio[0] && ext_rd_n && ext_wr_n) |=> (pin_out[0] == $past(pol_r[0]) ^ 1'b1))
    else $error("pin 0 strobe active with no external access");
  a_gpio_drive: assert property (
    (gpio[1] && !$past(gpio[1])) ##1 gpio[1] |-> (pin_out[1] == $past(data_r[1])))
    else $error("pin 1 does not follow its data bit");
  a_full_match: assert property (
    (cmp_flat[1:0] == 2'b00 && match[0]) |-> (ext_addr == base_flat[15:0]))
    else $error("full compare matched a different address");
  a_byte_match: assert property (
    (cmp_flat[1:0] == 2'b11) |-> (match[0] == (ext_addr[15:8] == base_hi_r[0])))
    else $error("high byte compare wrong");
  a_edge_flag: assert property (
    (irq_if.falling[0] && extra_irq_control_r[pcs_pkg::XI_TYPE2]) |=> extra_irq_control_r[pcs_pkg::XI_FLAG2])
    else $error("falling edge did not set interrupt two flag");
  a_level_req: assert property (
    (extra_irq_control_r[pcs_pkg::XI_EN3] && !extra_irq_control_r[pcs_pkg::XI_TYPE3] && !in3) |=> irq_three_req)
    else $error("low level did not request interrupt three");
  a_bitset_enable: assert property (
    (bit_wr && bit_addr == 8'hc2 && bit_wval && !sfr_wr) |=> extra_irq_control_r[pcs_pkg::XI_EN2])
    else $error("bit address c2 did not set interrupt two enable");
  a_vector_order: assert property (
    (req2_nxt && req3_nxt) |=> (irq_vector == pcs_pkg::VEC_IRQ_TWO))
    else $error("interrupt three vectored ahead of interrupt two");
  a_prio_follow: assert property (
    ##1 (irq_three_high == $past(extra_irq_control_r[pcs_pkg::XI_PRIO3])))
    else $error("interrupt three priority output stale");
  a_strobe_drive: assert property (
    !gpio[2] |=> pin_oe[2])
    else $error("pin 2 strobe not driven");
  a_gpio_release: assert property (
    gpio[0] |=> (pin_oe[0] == !$past(data_r[0])))
    else $error("pin 0 quasi drive wrong");
  a_read_strobe: assert property (
    (fun_flat[1:0] == 2'b01 && match[0] && !ext_rd_n) |=> (pin_out[0] == $past(pol_r[0])))
    else $error("pin 0 read strobe not asserted");
  a_write_strobe: assert property (
    (fun_flat[1:0] == 2'b10 && match[0] && !ext_wr_n) |=> (pin_out[0] == $past(pol_r[0])))
    else $error("pin 0 write strobe not asserted");
  a_ack_clear: assert property (
    (irq_two_ack && extra_irq_control_r[pcs_pkg::XI_TYPE2] && !irq_if.falling[0] && !sfr_wr && !bit_wr)
    |=> !extra_irq_control_r[pcs_pkg::XI_FLAG2])
    else $error("acknowledge did not clear interrupt two flag");
  a_set_wins: assert property (
    (irq_if.falling[0] && extra_irq_control_r[pcs_pkg::XI_TYPE2] && irq_two_ack) |=> extra_irq_control_r[pcs_pkg::XI_FLAG2])
    else $error("acknowledge beat a new edge on interrupt two");
  a_level_follow: assert property (
    (extra_irq_control_r[pcs_pkg::XI_EN3] && !extra_irq_control_r[pcs_pkg::XI_TYPE3]) |=> (irq_three_req == !$past(in3)))
    else $error("level request of interrupt three does not follow input");
endmodule
`default_nettype wire

// ==== tb/pcs_periph.sv ====
// Pin-side model: pull-ups and external devices that may hold pins low
`default_nettype none
module pcs_periph (
  input wire logic [3:0] pin_out,  // Port drive values
  input wire logic [3:0] pin_oe,   // Port drive enables
  input wire logic [3:0] pull_low, // External device holds a pin low
  output logic [3:0] pin_in        // Resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ns;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // A released quasi pin floats up through its pull-up
      pin_in[i] = pin_oe[i] ? pin_out[i] : ~pull_low[i];
    end
  end
endmodule
`default_nettype wire

// ==== tb/pcs_port4_bench.sv ====
// Self-checking bench of the four-pin multipurpose port
`default_nettype none
module pcs_port4_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, arst_n, sfr_wr, bit_wr, bit_wval, ext_rd_n, ext_wr_n, ack2, ack3;
  logic [7:0] sfr_addr, sfr_wdata, bit_addr, sfr_rdata, vec, clo, chi, pol, v;
  logic [15:0] ext_addr;
  logic [15:0] base [4];
  logic [3:0] pin_in, pin_out, pin_oe, pull_low;
  logic req2, req3, high2, high3;
  int n_mismatch = 0;
  int compares = 0;
  int kk;
  int sel;

  pcs_port4 i_dut (.clock(clock), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bit_addr(bit_addr), .bit_wr(bit_wr),
    .bit_wval(bit_wval), .ext_addr(ext_addr), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq_two_ack(ack2),
    .irq_three_ack(ack3), .irq_two_req(req2), .irq_three_req(req3),
    .irq_two_high(high2), .irq_three_high(high3), .irq_vector(vec));
  pcs_periph i_periph (.pin_out(pin_out), .pin_oe(pin_oe), .pull_low(pull_low),
    .pin_in(pin_in));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic give_verdict();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick();
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    tick();
    sfr_addr = a;
    tick();
    check(nm, {8'h00, sfr_rdata}, {8'h00, e});
  endtask
  task automatic bw(input logic [7:0] a, input logic d);
    tick();
    bit_addr = a;
    bit_wval = d;
    bit_wr = 1'b1;
    tick();
    bit_wr = 1'b0;
  endtask
  task automatic wait_req(input logic two);
    int i;
    i = 0;
    while (((two ? req2 : req3) !== 1'b1) && i < 8) begin
      tick();
      i++;
    end
    if ((two ? req2 : req3) !== 1'b1) begin
      check("irq request", {15'h0, two ? req2 : req3}, 16'h0001);
      give_verdict();
    end
  endtask

  function automatic logic [15:0] cmp_mask(input logic [1:0] c);
    case (c)
      2'h0: return 16'hffff;
      2'h1: return 16'hfffe;
      2'h2: return 16'hfffc;
      default: return 16'hff00;
    endcase
  endfunction
  function automatic logic [3:0] nib(input int p);
    return (p < 2) ? clo[4*p +: 4] : chi[4*(p-2) +: 4];
  endfunction
  function automatic logic strobe(input int p);
    logic [3:0] n;
    logic act;
    n = nib(p);
    act = ((ext_addr & cmp_mask(n[1:0])) == (base[p] & cmp_mask(n[1:0])))
      && ((n[2] && !ext_rd_n) || (n[3] && !ext_wr_n));
    return pol[4+p] ? act : !act;
  endfunction

  initial begin
    arst_n = 1'b0;
    {sfr_addr, sfr_wdata, bit_addr, sfr_wr, bit_wr, bit_wval} = '0;
    {ext_addr, pull_low, ack2, ack3} = '0;
    {ext_rd_n, ext_wr_n} = 2'b11;
    void'($urandom(3));
    repeat (5) @(posedge clock);
    #1;
    arst_n = 1'b1;
    check("pin_out", {12'h0, pin_out}, 16'h000f);
    check("pin_oe", {12'h0, pin_oe}, 16'h0000);
    rd(8'hc0, 8'h00, "extra_irq_control");
    rd(8'hc2, 8'h00, "port4_low_pins_config");
    rd(8'hc3, 8'h00, "port4_high_pins_config");
    rd(8'hd8, 8'h0f, "port4_pin_data");
    wr(8'h01, 8'h5a);
    rd(8'h01, 8'h00, "unmapped");
    // Quasi port output, then a single-bit write to data bit 1
    v = 8'($urandom);
    wr(8'hd8, v);
    tick();
    check("pin_out", {12'h0, pin_out}, {12'h0, v[3:0]});
    check("pin_oe", {12'h0, pin_oe}, {12'h0, ~v[3:0]});
    rd(8'hd8, {4'h0, v[3:0]}, "pin levels");
    bw(8'hd9, 1'b0);
    tick();
    check("pin_out", {12'h0, pin_out}, {12'h0, v[3:0] & 4'hd});
    wr(8'hd8, 8'h0f);
    // Strobe modes, compare widths and polarity with random settings
    for (int it = 0; it < 30; it++) begin
      clo = 8'($urandom);
      chi = 8'($urandom);
      pol = 8'($urandom);
      wr(8'hc2, clo);
      wr(8'hc3, chi);
      wr(pcs_pkg::ADDR_STROBE_POLARITY, pol);
      for (int p = 0; p < 4; p++) begin
        base[p] = 16'($urandom);
        wr(pcs_pkg::ADDR_BASE_HIGH[p], base[p][15:8]);
        wr(pcs_pkg::ADDR_BASE_LOW[p], base[p][7:0]);
      end
      rd(8'hc3, chi, "port4_high_pins_config");
      rd(8'hc2, clo, "port4_low_pins_config");
      rd(pcs_pkg::ADDR_STROBE_POLARITY, pol & 8'hf0, "strobe_polarity_control");
      rd(pcs_pkg::ADDR_BASE_HIGH[it % 4], base[it % 4][15:8], "pin_base_addr_high");
      rd(pcs_pkg::ADDR_BASE_LOW[it % 4], base[it % 4][7:0], "pin_base_addr_low");
      for (int k = 0; k < 5; k++) begin
        kk = $urandom % 4;
        sel = (k == 4) ? 0 : $urandom % 3;
        tick();
        ext_addr = ($urandom % 2) ? (base[kk] ^ (16'($urandom) & ~cmp_mask(2'(nib(kk))))) :
          16'($urandom);
        ext_rd_n = (sel != 1);
        ext_wr_n = (sel != 2);
        tick();
        for (int p = 0; p < 4; p++) begin
          if (nib(p) > 4'h3) begin
            check("strobe pin", {15'h0, pin_out[p]}, {15'h0, strobe(p)});
            check("strobe drive", {15'h0, pin_oe[p]}, 16'h0001);
          end else begin
            check("quasi drive", {15'h0, pin_oe[p]}, 16'h0000);
          end
        end
      end
    end
    wr(8'hc2, 8'h00);
    wr(8'hc3, 8'h00);
    // Edge-triggered interrupt two on pin 3, serviced by acknowledge
    bw(8'hc0, 1'b1);
    bw(8'hc2, 1'b1);
    pull_low[3] = 1'b1;
    wait_req(1'b1);
    check("irq_vector", {8'h00, vec}, 16'h0033);
    pull_low[3] = 1'b0;
    repeat (2) tick();
    check("irq_two_req", {15'h0, req2}, 16'h0001);
    rd(8'hc0, 8'h07, "extra_irq_control");
    ack2 = 1'b1;
    tick();
    ack2 = 1'b0;
    repeat (2) tick();
    check("irq_two_req", {15'h0, req2}, 16'h0000);
    rd(8'hc0, 8'h05, "extra_irq_control");
    // Level-triggered interrupt three on pin 2
    bw(8'hc6, 1'b1);
    pull_low[2] = 1'b1;
    wait_req(1'b0);
    check("irq_vector", {8'h00, vec}, 16'h003b);
    pull_low[2] = 1'b0;
    repeat (3) tick();
    check("irq_three_req", {15'h0, req3}, 16'h0000);
    bw(8'hc6, 1'b0);
    pull_low[2] = 1'b1;
    repeat (4) tick();
    check("irq_three_req", {15'h0, req3}, 16'h0000);
    check("irq_vector", {8'h00, vec}, 16'h0000);
    pull_low[2] = 1'b0;
    // Both extra interrupts pending: two comes first; an edge beats a same-cycle ack
    wr(8'hc0, 8'h45);
    pull_low = 4'hc;
    wait_req(1'b1);
    check("irq_vector", {8'h00, vec}, 16'h0033);
    check("irq_three_req", {15'h0, req3}, 16'h0001);
    pull_low[3] = 1'b0;
    tick();
    pull_low[3] = 1'b1;
    ack2 = 1'b1;
    tick();
    ack2 = 1'b0;
    repeat (2) tick();
    check("irq_two_req", {15'h0, req2}, 16'h0001);
    rd(8'hc0, 8'h47, "extra_irq_control");
    pull_low = 4'h0;
    wr(8'hc0, 8'h88);
    repeat (2) tick();
    check("irq_two_high", {15'h0, high2}, 16'h0001);
    check("irq_three_high", {15'h0, high3}, 16'h0001);
    rd(8'hc0, 8'h88, "extra_irq_control");
    give_verdict();
  end
endmodule
`default_nettype wire
